/* rtl/ebt_defines.vh */
// Constants for the eight-bit prescaled timer: offsets, fields, resets, timing
`ifndef EBT_DEFINES_VH
`define EBT_DEFINES_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EBT_ADDR_COUNT 4'h0
`define EBT_ADDR_OPTION 4'h1
`define EBT_ADDR_PRESC_STAT 4'h2
// ----------------------------------------
// Option field positions
// ----------------------------------------
`define EBT_OPT_CS_BIT 5
`define EBT_OPT_SE_BIT 4
`define EBT_OPT_PA_BIT 3
`define EBT_OPT_PS_MSB 2
`define EBT_OPT_PS_LSB 0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define EBT_RST_OPTION 8'hFF
`define EBT_RST_COUNT 8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define EBT_WRITE_HOLD_CYCLES 2'h2
`define EBT_INSTR_DIV 2'h3
`endif

/* rtl/ebt_prescaler.v */
// Eight-bit prescaler divider, shared between timer and watchdog
`timescale 1ns/1ps
`default_nettype none
module ebt_prescaler #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_nrst,
  // Control
  input wire i_tick,
  input wire i_clear,
  input wire [2:0] i_rate,
  // Output
  output reg o_tick
);
  reg [WIDTH-1:0] cnt_reg;
  wire [WIDTH-1:0] cnt_next;
  wire [WIDTH-1:0] mask;
  // Ratio is 2 to the power rate+1
  // Four-bit shift amount, so rate 7 reaches a full eight-bit mask
  assign mask = ({{(WIDTH-1){1'b0}}, 1'b1} << ({1'b0, i_rate} + 4'h1))
    - {{(WIDTH-1){1'b0}}, 1'b1};
  assign cnt_next = cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= {WIDTH{1'b0}};
      o_tick <= 1'b0;
    end else if (i_clear) begin
      cnt_reg <= {WIDTH{1'b0}};
      o_tick <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (i_tick) begin
        cnt_reg <= cnt_next;
        // Full 8-bit wrap gives 1:256 when mask is all ones
        o_tick <= ((cnt_reg & mask) == mask);
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/ebt_timer.v */
// Top of the eight-bit prescaled timer with register port
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ebt_defines.vh"
module ebt_timer (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_nrst,
  // Register port
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // External count pin
  input wire i_external_count_input,
  // Watchdog side
  input wire i_wdt_tick,
  output reg o_wdt_tick,
  output reg o_instr_tick
);
  // ----------------------------------------
  // Registers and synchronisers
  // ----------------------------------------
  reg [7:0] timer_count_reg;
  reg [7:0] option_reg;
  reg [1:0] div_reg;
  reg [1:0] hold_reg;
  reg pin_meta_reg;
  reg pin_sync_reg;
  reg pin_last_reg;
  reg presc_tick_reg;
  wire clock_source_select = option_reg[`EBT_OPT_CS_BIT];
  wire source_edge_select = option_reg[`EBT_OPT_SE_BIT];
  wire prescaler_assign = option_reg[`EBT_OPT_PA_BIT];
  wire [2:0] prescale_rate = option_reg[`EBT_OPT_PS_MSB:`EBT_OPT_PS_LSB];
  wire instr_tick = (div_reg == `EBT_INSTR_DIV);
  wire pin_edge;
  wire src_tick;
  wire presc_in;
  wire presc_out;
  wire count_tick;
  wire count_wr = i_wr && (i_addr == `EBT_ADDR_COUNT);
  wire opt_wr = i_wr && (i_addr == `EBT_ADDR_OPTION);

  // ----------------------------------------
  // Instruction clock divider
  // ----------------------------------------
  // Four system cycles make one instruction cycle
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_reg <= 2'h0;
      o_instr_tick <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1;
      o_instr_tick <= instr_tick;
    end
  end

  // ----------------------------------------
  // Pin synchroniser and edge detect
  // ----------------------------------------
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_last_reg <= 1'b0;
    end else begin
      pin_meta_reg <= i_external_count_input;
      pin_sync_reg <= pin_meta_reg;
      pin_last_reg <= pin_sync_reg;
    end
  end
  assign pin_edge = source_edge_select ? (pin_last_reg & ~pin_sync_reg)
                                       : (~pin_last_reg & pin_sync_reg);
  assign src_tick = clock_source_select ? pin_edge : instr_tick;

  // ----------------------------------------
  // Prescaler routing
  // ----------------------------------------
  // One divider; the unassigned user bypasses it
  assign presc_in = prescaler_assign ? i_wdt_tick : src_tick;
  ebt_prescaler #(
    .WIDTH(8)
  ) u_presc (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_tick(presc_in),
    .i_clear(opt_wr),
    .i_rate(prescale_rate),
    .o_tick(presc_out)
  );
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      presc_tick_reg <= 1'b0;
      o_wdt_tick <= 1'b0;
    end else begin
      presc_tick_reg <= presc_out;
      o_wdt_tick <= prescaler_assign ? presc_out : i_wdt_tick;
    end
  end
  assign count_tick = prescaler_assign ? src_tick : presc_tick_reg;

  // ----------------------------------------
  // Count and option registers
  // ----------------------------------------
  // Hold counts instruction cycles so the written value is seen twice
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      timer_count_reg <= `EBT_RST_COUNT;
      option_reg <= `EBT_RST_OPTION;
      hold_reg <= 2'h0;
    end else begin
      if (opt_wr) begin
        option_reg <= i_wdata;
      end
      if (count_wr) begin
        timer_count_reg <= i_wdata;
        hold_reg <= `EBT_WRITE_HOLD_CYCLES;
      end else begin
        if (instr_tick && hold_reg != 2'h0) begin
          hold_reg <= hold_reg - 2'h1;
        end
        if (count_tick && hold_reg == 2'h0) begin
          timer_count_reg <= timer_count_reg + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Prescaler count never appears here
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `EBT_ADDR_COUNT: o_rdata <= timer_count_reg;
        `EBT_ADDR_OPTION: o_rdata <= option_reg;
        `EBT_ADDR_PRESC_STAT: o_rdata <= {7'h00, hold_reg != 2'h0};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

/* sim/ebt_timer_chk.sv */
// Port assertions for the eight-bit prescaled timer
`timescale 1ns/1ps
`default_nettype none
module ebt_timer_chk (
  // Clock, reset, register port
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // Watchdog side
  input wire logic i_wdt_tick,
  input wire logic o_wdt_tick,
  input wire logic o_instr_tick
);
  // Option shadow, to know where the prescaler sits
  logic [7:0] opt_reg;
  always_ff @(posedge i_sys_clk or negedge i_nrst)
    if (!i_nrst) opt_reg <= 8'hFF;
    else if (i_wr && i_addr == 4'h1) opt_reg <= i_wdata;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  instr_rate_a: assert property (o_instr_tick |=> !o_instr_tick [*3] ##1 o_instr_tick)
    else $error("instruction tick spacing");
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read");
  hidden_read_a: assert property ($past(i_rd) && $past(i_addr) > 4'h2 |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  write_hold_a: assert property (i_wr && i_addr == 4'h0 ##1 i_rd ##1 i_rd && i_addr == 4'h0
    |=> o_rdata == $past(i_wdata, 3))
    else $error("count moved during hold");
  hold_flag_a: assert property (i_wr && i_addr == 4'h0 ##1 i_rd && i_addr == 4'h2
    |=> o_rdata[0])
    else $error("hold flag low");
  opt_back_a: assert property (i_wr && i_addr == 4'h1 ##1 i_rd && i_addr == 4'h1
    |=> o_rdata == $past(i_wdata, 2))
    else $error("option readback");
  wdt_pass_a: assert property (!$past(opt_reg[3]) |-> o_wdt_tick == $past(i_wdt_tick))
    else $error("watchdog tick not passed");
  wdt_divided_a: assert property (o_wdt_tick && opt_reg[3] && $past(opt_reg[3])
    |=> !o_wdt_tick)
    else $error("watchdog tick not divided");
endmodule
bind ebt_timer ebt_timer_chk ebt_timer_chk_i (.i_sys_clk, .i_nrst, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .i_wdt_tick, .o_wdt_tick, .o_instr_tick);
`default_nettype wire

/* sim/ebt_pin_src.sv */
// Model of the pulse source on the count pin
`timescale 1ns/1ps
`default_nettype none
module ebt_pin_src (
  // Clock and command
  input wire logic i_sys_clk,
  input wire logic i_go,
  input wire logic [5:0] i_edges,
  input wire logic i_slow,
  // Pin and status
  output logic o_pin,
  output logic o_busy
);
  logic [5:0] left_reg = 6'h00;
  logic [3:0] gap_reg = 4'h0;
  initial o_pin = 1'b0;
  assign o_busy = left_reg != 6'h00;
  always @(posedge i_sys_clk) begin
    if (i_go) left_reg <= i_edges;
    else if (o_busy && gap_reg == 4'h0) begin
      o_pin <= !o_pin;
      left_reg <= left_reg - 6'h01;
    end
    gap_reg <= (gap_reg == 4'h0) ? (i_slow ? 4'h9 : 4'h3) : gap_reg - 4'h1;
  end
endmodule
`default_nettype wire

/* sim/ebt_timer_test.sv */
// Self-checking bench for the eight-bit prescaled timer
`timescale 1ns/1ps
`default_nettype none
module ebt_timer_test;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, wdt_in = 1'b0;
  logic go = 1'b0, slow = 1'b0, pin, busy, wdt_out, itick;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, v;
  logic [5:0] edges = 6'h00;
  logic [7:0] exp_q[$];
  int errors = 0, comparisons = 0, n;
  ebt_timer ebt_timer_i (.i_sys_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_external_count_input(pin),
    .i_wdt_tick(wdt_in), .o_wdt_tick(wdt_out), .o_instr_tick(itick));
  ebt_pin_src ebt_pin_src_i (.i_sys_clk(clk), .i_go(go), .i_edges(edges), .i_slow(slow),
    .o_pin(pin), .o_busy(busy));
  initial forever #10 clk = !clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      errors++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // Read: d is the expected answer, noted for the monitor
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    if (!w) exp_q.push_back(d);
    @(posedge clk);
  endtask
  task automatic idle(input int k);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (k) @(posedge clk);
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge clk);
      while (itick !== 1'b1) @(posedge clk);
    end
  endtask
  task automatic stop_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    wdt_in <= ($urandom % 4) != 0;
    rd_d <= rd;
    if (rd_d) check(rdata, exp_q.pop_front());
  end
  initial begin
    #500000;
    errors++;
    stop_test;
  end
  initial begin
    void'($urandom(78744));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    acc(1, 4'h1, 8'h08);
    acc(0, 4'h1, 8'h08);
    acc(0, 4'hF, 8'h00);
    idle(0);
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'hFE : 8'($urandom);
      ticks(1);
      acc(1, 4'h0, v);
      acc(0, 4'h2, 8'h01);
      acc(0, 4'h0, v);
      idle(0);
      ticks(6);
      idle(2);
      acc(0, 4'h0, v + 8'h04);
      idle(1);
    end
    // Rate 1:2 skipped: its first tick lands inside the write hold
    for (int r = 1; r < 8; r++) begin
      v = 8'($urandom);
      ticks(1);
      acc(1, 4'h1, 8'(r));
      acc(0, 4'h1, 8'(r));
      acc(1, 4'h0, v);
      idle(0);
      ticks(2 * (2 << r) + 1);
      idle(2);
      acc(0, 4'h0, v + 8'h02);
      idle(1);
    end
    for (int s = 0; s < 2; s++) begin
      n = 1 + $urandom % 20;
      v = 8'($urandom);
      acc(1, 4'h1, s ? 8'h39 : 8'h29);
      acc(1, 4'h0, v);
      idle(16);
      edges <= 6'(2 * n + 1);
      slow <= s[0];
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
      while (busy) @(posedge clk);
      idle(12);
      acc(0, 4'h0, v + 8'(n + 1));
      idle(3);
    end
    stop_test;
  end
endmodule
`default_nettype wire
